// [psw_defines.svh]
`ifndef PSW_DEFINES_SVH
`define PSW_DEFINES_SVH
// ----------------------------------------
// status word bit positions
// ----------------------------------------
`define PSW_BIT_CY   4'd0
`define PSW_BIT_P    4'd2
`define PSW_BIT_AC   4'd4
`define PSW_BIT_Z    4'd6
`define PSW_BIT_S    4'd7
`define PSW_BIT_BRK  4'd8
`define PSW_BIT_IE   4'd9
`define PSW_BIT_DIR  4'd10
`define PSW_BIT_V    4'd11
`define PSW_BIT_MD   4'd15
// ----------------------------------------
// constant bits and reset values
// ----------------------------------------
`define PSW_ONES_MASK   16'h7002
`define PSW_FLAG_MASK   16'h8fd5
`define PSW_RESET_VAL   16'hf002
`define PSW_SS_VECTOR   8'h01
`endif

// [psw_pkg.sv]
package psw_pkg;
   // ----------------------------------------
   // flag update classes
   // ----------------------------------------
   typedef enum logic [3:0] {
      PSW_OP_NONE,
      PSW_OP_ADDSUB,
      PSW_OP_LOGIC,
      PSW_OP_MUL,
      PSW_OP_MULIMM,
      PSW_OP_DIV,
      PSW_OP_SHL,
      PSW_OP_SHR
   } psw_op_t;
   // ----------------------------------------
   // control/status word sources
   // ----------------------------------------
   typedef enum logic [3:0] {
      PSW_CT_NONE,
      PSW_CT_SET_IE,
      PSW_CT_CLR_IE,
      PSW_CT_SET_DIR,
      PSW_CT_CLR_DIR,
      PSW_CT_CMC,
      PSW_CT_SET_CY,
      PSW_CT_CLR_CY,
      PSW_CT_LOAD_AH,
      PSW_CT_POP,
      PSW_CT_INTERRUPT_RETURN_INSTR,
      PSW_CT_RETURN_FROM_EMULATION_INSTR,
      PSW_CT_BREAK_TO_EMULATION_INSTR,
      PSW_CT_NATIVE_CALL_INSTR,
      PSW_CT_INT_ACK
   } psw_ctl_t;
endpackage

// [psw_if.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// flag result carrier from evaluator
// ----------------------------------------
interface psw_if;
   logic [15:0] res;   // operation result
   logic        wide;  // word result
   logic        cy;
   logic        p;
   logic        ac;
   logic        z;
   logic        s;
   logic        v;
   logic [5:0]  upd;   // cy,p,ac,z,s,v update enables
   modport eval (input res, input wide, output cy, output p, output ac, output z, output s, output v, output upd);
   modport core (output res, output wide, input cy, input p, input ac, input z, input s, input v, input upd);
endinterface
`default_nettype wire

// [psw_flag_eval.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// combinational arithmetic flag evaluator
// ----------------------------------------
module psw_flag_eval
(
   psw_if.eval              fi,
   input  wire psw_pkg::psw_op_t op,
   input  wire logic [15:0] opa,
   input  wire logic [15:0] opb,
   input  wire logic        sub,
   input  wire logic        cin,
   input  wire logic        sgn,
   input  wire logic [31:0] prod,
   input  wire logic        shout
);
   // ----------------------------------------
   // adder with per-bit carries
   // ----------------------------------------
   wire [15:0] b_eff   = sub ? ~opb : opb;
   wire        c0      = sub ? ~cin : cin;
   wire [16:0] sum     = {1'b0, opa} + {1'b0, b_eff} + {16'h0000, c0};
   wire [15:0] cvec    = opa ^ b_eff ^ sum[15:0];    // carry into each bit
   wire        co7     = sum[8] ^ opa[8] ^ b_eff[8]; // carry out of bit 7
   wire        co15    = sum[16];
   wire        w       = fi.wide;
   wire [15:0] r       = fi.res;
   // borrow is inverted carry when subtracting
   wire        cy_add  = (w ? co15 : co7) ^ sub;
   wire        v_add   = w ? (co15 ^ cvec[15]) : (co7 ^ cvec[7]);
   wire        ac_add  = cvec[4] ^ sub;
   // ----------------------------------------
   // multiply overflow test
   // ----------------------------------------
   wire        hi_zero = w ? (prod[31:16] == 16'h0000) : (prod[15:8] == 8'h00);
   wire        hi_sext = w ? (prod[31:16] == {16{prod[15]}}) : (prod[15:8] == {8{prod[7]}});
   wire        mul_ov  = sgn ? ~hi_sext : ~hi_zero;
   wire        imm_ov  = prod[31:16] != {16{prod[15]}};
   wire        msb     = w ? r[15] : r[7];
   wire        msb2    = w ? r[14] : r[6];
   // ----------------------------------------
   // flag values and update enables
   // ----------------------------------------
   assign fi.p  = ~^r[7:0];
   assign fi.z  = w ? (r == 16'h0000) : (r[7:0] == 8'h00);
   assign fi.s  = msb;
   assign fi.ac = ac_add;
   always_comb
   begin
      fi.cy  = 1'b0;
      fi.v   = 1'b0;
      fi.upd = 6'b000000;
      case (op)
         psw_pkg::PSW_OP_ADDSUB:
         begin
            fi.cy  = cy_add;
            fi.v   = v_add;
            fi.upd = 6'b111111;
         end
         psw_pkg::PSW_OP_LOGIC:
         begin
            fi.cy  = 1'b0;
            fi.v   = 1'b0;
            fi.upd = 6'b110111;   // ac kept
         end
         psw_pkg::PSW_OP_MUL:
         begin
            fi.cy  = mul_ov;
            fi.v   = mul_ov;
            fi.upd = 6'b100001;   // p,ac,z,s kept
         end
         psw_pkg::PSW_OP_MULIMM:
         begin
            fi.cy  = imm_ov;
            fi.v   = imm_ov;
            fi.upd = 6'b100001;
         end
         psw_pkg::PSW_OP_DIV:
         begin
            fi.v   = 1'b0;
            fi.upd = 6'b000001;   // cy,p,ac,z,s kept
         end
         psw_pkg::PSW_OP_SHL:
         begin
            fi.cy  = shout;
            fi.v   = shout ^ msb;
            fi.upd = 6'b110111;
         end
         psw_pkg::PSW_OP_SHR:
         begin
            fi.cy  = shout;
            fi.v   = msb ^ msb2;
            fi.upd = 6'b110111;
         end
         default:
         begin
            fi.upd = 6'b000000;
         end
      endcase
   end
endmodule // psw_flag_eval
`default_nettype wire

// [psw_core.sv]
`timescale 1ns/100ps
`default_nettype none
`include "psw_defines.svh"
module psw_core
#(
   parameter bit HAS_MODE = 1'b1  // variant carries the mode flag
)
(
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire psw_pkg::psw_op_t    op,
   input  wire logic                wide,
   input  wire logic [15:0]         res,
   input  wire logic [15:0]         opa,
   input  wire logic [15:0]         opb,
   input  wire logic                sub,
   input  wire logic                use_cin,
   input  wire logic                sgn,
   input  wire logic [31:0]         prod,
   input  wire logic                shout,
   input  wire psw_pkg::psw_ctl_t   ctl,
   input  wire logic [7:0]          accumulator_high_byte,
   input  wire logic [15:0]         stack_word,
   input  wire logic                insn_done,
   input  wire logic                irq_in,
   output logic [15:0]              processor_status_word,
   output logic                     mode_write_protect,
   output logic                     irq_accept,
   output logic                     step_trap_req,
   output logic [7:0]               step_trap_vector,
   output logic                     addr_step_down,
   output logic                     native_mode
);
   // ----------------------------------------
   // flag evaluator
   // ----------------------------------------
   psw_if fi ();
   assign fi.res  = res;
   assign fi.wide = wide;

   logic [15:0] psw_q;   // stored flags
   logic [15:0] psw_d;
   logic        wp_q;    // mode write protect
   logic        wp_d;

   psw_flag_eval u_eval
   (
      .fi    (fi),
      .op    (op),
      .opa   (opa),
      .opb   (opb),
      .sub   (sub),
      .cin   (use_cin & psw_q[`PSW_BIT_CY]),
      .sgn   (sgn),
      .prod  (prod),
      .shout (shout)
   );

   // ----------------------------------------
   // word formatting helper
   // ----------------------------------------
   // forces the constant bits; used for stored and shown word
   function automatic logic [15:0] psw_fmt(input logic [15:0] v);
      logic [15:0] t;
      t = (v & `PSW_FLAG_MASK) | `PSW_ONES_MASK;
      if (!HAS_MODE)
         t[`PSW_BIT_MD] = 1'b1;
      return t;
   endfunction

   // ----------------------------------------
   // arithmetic flag merge
   // ----------------------------------------
   logic [15:0] arith;
   always_comb
   begin
      arith = psw_q;
      if (fi.upd[5]) arith[`PSW_BIT_CY] = fi.cy;
      if (fi.upd[4]) arith[`PSW_BIT_P]  = fi.p;
      if (fi.upd[3]) arith[`PSW_BIT_AC] = fi.ac;
      if (fi.upd[2]) arith[`PSW_BIT_Z]  = fi.z;
      if (fi.upd[1]) arith[`PSW_BIT_S]  = fi.s;
      if (fi.upd[0]) arith[`PSW_BIT_V]  = fi.v;
   end

   // stacked word with mode held while protected
   wire [15:0] reload = {(wp_q ? psw_q[`PSW_BIT_MD] : stack_word[15]), stack_word[14:0]};

   // ----------------------------------------
   // control actions, take precedence over arithmetic
   // ----------------------------------------
   always_comb
   begin
      psw_d = arith;
      wp_d  = wp_q;
      case (ctl)
         psw_pkg::PSW_CT_SET_IE:  psw_d[`PSW_BIT_IE]  = 1'b1;
         psw_pkg::PSW_CT_CLR_IE:  psw_d[`PSW_BIT_IE]  = 1'b0;
         psw_pkg::PSW_CT_SET_DIR: psw_d[`PSW_BIT_DIR] = 1'b1;
         psw_pkg::PSW_CT_CLR_DIR: psw_d[`PSW_BIT_DIR] = 1'b0;
         psw_pkg::PSW_CT_CMC:     psw_d[`PSW_BIT_CY]  = ~psw_q[`PSW_BIT_CY];
         psw_pkg::PSW_CT_SET_CY:  psw_d[`PSW_BIT_CY]  = 1'b1;
         psw_pkg::PSW_CT_CLR_CY:  psw_d[`PSW_BIT_CY]  = 1'b0;
         psw_pkg::PSW_CT_LOAD_AH:
         begin
            // low byte only; overflow and above untouched
            psw_d[7:0] = accumulator_high_byte;
         end
         psw_pkg::PSW_CT_POP:     psw_d = reload;
         psw_pkg::PSW_CT_INTERRUPT_RETURN_INSTR:    psw_d = reload;
         psw_pkg::PSW_CT_RETURN_FROM_EMULATION_INSTR:
         begin
            // reload then return to native and lock mode
            psw_d               = stack_word;
            psw_d[`PSW_BIT_MD]  = 1'b1;
            wp_d                = 1'b1;
         end
         psw_pkg::PSW_CT_BREAK_TO_EMULATION_INSTR:
         begin
            psw_d[`PSW_BIT_MD]  = 1'b0;
            wp_d                = 1'b0;
         end
         psw_pkg::PSW_CT_NATIVE_CALL_INSTR:   psw_d[`PSW_BIT_MD]  = 1'b1;
         psw_pkg::PSW_CT_INT_ACK:
         begin
            // old word already on processor_status_word for the push
            psw_d[`PSW_BIT_IE]  = 1'b0;
            psw_d[`PSW_BIT_BRK] = 1'b0;
         end
         default:
         begin
            psw_d = arith;
         end
      endcase
      psw_d = psw_fmt(psw_d);
   end

   // ----------------------------------------
   // status word and protect state
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         psw_q <= `PSW_RESET_VAL;
         wp_q  <= 1'b1;
      end
      else
      begin
         psw_q <= psw_d;
         wp_q  <= wp_d;
      end
   end

   // ----------------------------------------
   // control outputs, registered
   // ----------------------------------------
   // irq input is same-domain core logic, so not synchronised
   wire irq_ok   = irq_in & psw_q[`PSW_BIT_IE] & (ctl != psw_pkg::PSW_CT_INT_ACK);
   wire trap_now = insn_done & psw_q[`PSW_BIT_BRK];

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         processor_status_word <= `PSW_RESET_VAL;
         mode_write_protect    <= 1'b1;
         irq_accept            <= 1'b0;
         step_trap_req         <= 1'b0;
         step_trap_vector      <= 8'h00;
         addr_step_down        <= 1'b0;
         native_mode           <= 1'b1;
      end
      else
      begin
         processor_status_word <= psw_d;
         mode_write_protect    <= wp_d;
         irq_accept            <= irq_ok;
         step_trap_req         <= trap_now;
         step_trap_vector      <= `PSW_SS_VECTOR;
         addr_step_down        <= psw_d[`PSW_BIT_DIR];
         native_mode           <= psw_d[`PSW_BIT_MD];
      end
   end
endmodule // psw_core
`default_nettype wire

// [psw_core_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// status word checker
// ----------------------------------------
module swf_chk
#(
   parameter bit HAS_MODE = 1'b1  // same variant as the checked core
)
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire psw_pkg::psw_op_t  op,
   input  wire psw_pkg::psw_ctl_t ctl,
   input  wire logic [7:0]        accumulator_high_byte,
   input  wire logic              insn_done,
   input  wire logic              irq_in,
   input  wire logic [15:0]       processor_status_word,
   input  wire logic              mode_write_protect,
   input  wire logic              irq_accept,
   input  wire logic              step_trap_req,
   input  wire logic [7:0]        step_trap_vector,
   input  wire logic              addr_step_down
);
   // one domain, so one clock and one disable for all
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_fixed_bits: assert property (
      (processor_status_word & 16'h702a) == 16'h7002) else $error("fixed bits moved");
   a_mode_absent: assert property (
      !HAS_MODE |-> processor_status_word[15]) else $error("top bit low without mode flag");
   a_entry_clears: assert property (
      ctl == psw_pkg::PSW_CT_INT_ACK |=> processor_status_word[9:8] == 2'b00) else $error("entry kept allow or trap");
   // high half must hold while only the low byte is loaded
   a_byte_load: assert property (
      ctl == psw_pkg::PSW_CT_LOAD_AH && op == psw_pkg::PSW_OP_NONE |=>
      processor_status_word[7:0] == (($past(accumulator_high_byte) & 8'hd5) | 8'h02) &&
      processor_status_word[15:8] == $past(processor_status_word[15:8])) else $error("byte load wrong");
   a_mode_kept: assert property (
      ctl inside {psw_pkg::PSW_CT_POP, psw_pkg::PSW_CT_INTERRUPT_RETURN_INSTR} && mode_write_protect |=>
      $stable(processor_status_word[15])) else $error("protected mode bit reloaded");
   a_mode_break: assert property (
      ctl == psw_pkg::PSW_CT_BREAK_TO_EMULATION_INSTR |=> processor_status_word[15] != HAS_MODE &&
      (!mode_write_protect || !HAS_MODE)) else $error("break did not leave native mode");
   a_mode_return: assert property (
      ctl == psw_pkg::PSW_CT_RETURN_FROM_EMULATION_INSTR |=> processor_status_word[15] &&
      (mode_write_protect || !HAS_MODE)) else $error("return did not protect mode");
   a_allow_ctl: assert property (
      ctl inside {psw_pkg::PSW_CT_SET_IE, psw_pkg::PSW_CT_CLR_IE} |=>
      processor_status_word[9] == ($past(ctl) == psw_pkg::PSW_CT_SET_IE)) else $error("allow flag wrong");
   a_irq_gated: assert property (
      irq_accept |-> $past(irq_in) && $past(processor_status_word[9])) else $error("irq taken while masked");
   a_step_trap: assert property (
      step_trap_req |-> $past(insn_done) && $past(processor_status_word[8]) && step_trap_vector == 8'h01)
      else $error("stray step trap");
   a_dir_out: assert property (
      addr_step_down == processor_status_word[10]) else $error("step direction differs");
endmodule // swf_chk
bind psw_core swf_chk #(.HAS_MODE(HAS_MODE)) chk_u (.*);
`default_nettype wire

// [cpu_status_word_flag_logic_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module cpu_status_word_flag_logic_tb;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic              clk = 1'b0;
   logic              rstn = 1'b0;
   psw_pkg::psw_op_t  op = psw_pkg::PSW_OP_NONE;
   psw_pkg::psw_ctl_t ctl = psw_pkg::PSW_CT_NONE;
   logic              wide = 1'b0;
   logic              sub = 1'b0;
   logic              use_cin = 1'b0;   // carry chaining left untested
   logic              sgn = 1'b0;
   logic              shout = 1'b0;
   logic              insn_done = 1'b0;
   logic              irq_in = 1'b0;
   logic [15:0]       res = 16'h0000;
   logic [15:0]       opa = 16'h0000;
   logic [15:0]       opb = 16'h0000;
   logic [15:0]       stack_word = 16'h0000;
   logic [31:0]       prod = 32'h0000_0000;
   logic [7:0]        accumulator_high_byte = 8'h00;
   logic [15:0]       processor_status_word;
   logic [15:0]       word_nomode;       // variant without the mode flag
   logic [7:0]        step_trap_vector;
   logic              mode_write_protect;
   logic              irq_accept;
   logic              step_trap_req;
   logic              addr_step_down;
   logic              native_mode;
   int                mismatches = 0;
   int                compares = 0;
   always #2 clk = ~clk;   // 250 MHz
   psw_core dut_u (.*);
   // both variants see the same stimulus
   psw_core #(.HAS_MODE(1'b0)) dut_nm (.processor_status_word(word_nomode), .mode_write_protect(),
      .irq_accept(), .step_trap_req(), .step_trap_vector(), .addr_step_down(), .native_mode(), .*);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one cycle of request, then idle again
   task automatic pulse();
      @(negedge clk);
      op = psw_pkg::PSW_OP_NONE;
      ctl = psw_pkg::PSW_CT_NONE;
      insn_done = 1'b0;
      irq_in = 1'b0;
   endtask
   task automatic do_ctl(input psw_pkg::psw_ctl_t c, input logic [15:0] sw, input logic [15:0] exp);
      ctl = c;
      stack_word = sw;
      pulse();
      check(processor_status_word, exp);
   endtask
   // add/subtract flags worked out from the operands alone
   task automatic addsub(input logic w, input logic s, input logic [15:0] a, input logic [15:0] b);
      logic [16:0] f;
      logic [4:0]  h;
      logic [15:0] r;
      int          n;
      n = w ? 15 : 7;
      f = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
      h = s ? {1'b0, a[3:0]} - {1'b0, b[3:0]} : {1'b0, a[3:0]} + {1'b0, b[3:0]};
      r = w ? f[15:0] : {8'h00, f[7:0]};
      op = psw_pkg::PSW_OP_ADDSUB;
      wide = w;
      sub = s;
      opa = a;
      opb = b;
      res = r;
      pulse();
      check(processor_status_word & 16'h08d5, {4'h0, ((a[n] == b[n]) ^ s) && (r[n] != a[n]), 3'h0, r[n],
         w ? r == 16'h0 : r[7:0] == 8'h0, 1'b0, h[4], 1'b0, ~^r[7:0], 1'b0, w ? f[16] : f[8]});
   endtask
   // other classes: undefined flags are masked out
   task automatic flag_op(input psw_pkg::psw_op_t o, input logic w, input logic [31:0] v, input logic sx,
                          input logic [15:0] exp);
      op = o;
      wide = w;
      res = v[15:0];
      prod = v;
      sgn = sx;
      shout = sx;
      pulse();
      check(processor_status_word & (o inside {psw_pkg::PSW_OP_SHL, psw_pkg::PSW_OP_SHR} ? 16'h08c5 :
         o == psw_pkg::PSW_OP_LOGIC ? 16'h08d5 : 16'h0801), exp);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      check(processor_status_word, 16'hf002);
      check(word_nomode, 16'hf002);
      check({6'h00, mode_write_protect, native_mode, step_trap_vector}, 16'h0300);
      @(negedge clk);
      check({8'h00, step_trap_vector}, 16'h0001);
      $display("reset test done");
      do_ctl(psw_pkg::PSW_CT_SET_IE, 16'h0, 16'hf202);
      irq_in = 1'b1;
      pulse();
      check({15'h0, irq_accept}, 16'h0001);
      do_ctl(psw_pkg::PSW_CT_CLR_IE, 16'h0, 16'hf002);
      irq_in = 1'b1;
      pulse();
      check({15'h0, irq_accept}, 16'h0000);
      do_ctl(psw_pkg::PSW_CT_SET_DIR, 16'h0, 16'hf402);
      check({15'h0, addr_step_down}, 16'h0001);
      do_ctl(psw_pkg::PSW_CT_CLR_DIR, 16'h0, 16'hf002);
      do_ctl(psw_pkg::PSW_CT_SET_CY, 16'h0, 16'hf003);
      do_ctl(psw_pkg::PSW_CT_CLR_CY, 16'h0, 16'hf002);
      do_ctl(psw_pkg::PSW_CT_CMC, 16'h0, 16'hf003);
      accumulator_high_byte = 8'hff;
      do_ctl(psw_pkg::PSW_CT_LOAD_AH, 16'h0, 16'hf0d7);
      accumulator_high_byte = 8'h00;
      do_ctl(psw_pkg::PSW_CT_LOAD_AH, 16'h0, 16'hf002);
      do_ctl(psw_pkg::PSW_CT_POP, 16'h0f00, 16'hff02);
      do_ctl(psw_pkg::PSW_CT_INT_ACK, 16'h0, 16'hfc02);
      do_ctl(psw_pkg::PSW_CT_BREAK_TO_EMULATION_INSTR, 16'h0, 16'h7c02);
      check({14'h0, mode_write_protect, native_mode}, 16'h0000);
      check(word_nomode, 16'hfc02);
      do_ctl(psw_pkg::PSW_CT_INTERRUPT_RETURN_INSTR, 16'h8000, 16'hf002);
      do_ctl(psw_pkg::PSW_CT_POP, 16'h0000, 16'h7002);
      do_ctl(psw_pkg::PSW_CT_NATIVE_CALL_INSTR, 16'h0, 16'hf002);
      do_ctl(psw_pkg::PSW_CT_RETURN_FROM_EMULATION_INSTR, 16'h0000, 16'hf002);
      do_ctl(psw_pkg::PSW_CT_POP, 16'h0100, 16'hf102);
      insn_done = 1'b1;
      pulse();
      check({15'h0, step_trap_req}, 16'h0001);
      do_ctl(psw_pkg::PSW_CT_INT_ACK, 16'h0, 16'hf002);
      $display("control test done");
      addsub(1'b0, 1'b0, 16'h007f, 16'h0001);
      addsub(1'b0, 1'b0, 16'h00ff, 16'h0001);
      addsub(1'b0, 1'b1, 16'h0000, 16'h0001);
      addsub(1'b1, 1'b1, 16'h8000, 16'h0001);
      addsub(1'b1, 1'b0, 16'hffff, 16'h0001);
      addsub(1'b1, 1'b0, 16'h0ff8, 16'h0008);
      flag_op(psw_pkg::PSW_OP_LOGIC, 1'b1, 32'h0, 1'b0, 16'h0054);
      flag_op(psw_pkg::PSW_OP_LOGIC, 1'b0, 32'h0180, 1'b0, 16'h0090);
      flag_op(psw_pkg::PSW_OP_MUL, 1'b0, 32'hff80, 1'b1, 16'h0000);
      flag_op(psw_pkg::PSW_OP_MUL, 1'b1, 32'hffff_8000, 1'b1, 16'h0000);
      flag_op(psw_pkg::PSW_OP_MUL, 1'b1, 32'h0000_8000, 1'b1, 16'h0801);
      flag_op(psw_pkg::PSW_OP_DIV, 1'b1, 32'h0, 1'b0, 16'h0001);
      flag_op(psw_pkg::PSW_OP_MUL, 1'b1, 32'h0001_0000, 1'b0, 16'h0801);
      flag_op(psw_pkg::PSW_OP_MULIMM, 1'b1, 32'h0005, 1'b1, 16'h0000);
      flag_op(psw_pkg::PSW_OP_SHL, 1'b1, 32'h4000, 1'b1, 16'h0805);
      flag_op(psw_pkg::PSW_OP_SHL, 1'b0, 32'h0080, 1'b1, 16'h0081);
      flag_op(psw_pkg::PSW_OP_SHR, 1'b1, 32'h4000, 1'b0, 16'h0804);
      $display("arithmetic test done");
      tally_and_finish();
   end
endmodule // cpu_status_word_flag_logic_tb
`default_nettype wire
